// >>> design/fwk_guard.sv
// Flash write lock and key guard with its lock register.
// Assumes the core issues one-cycle SFR strobes and the flash controller
// raises a start pulse per operation and a done pulse when it finishes.
//
// Operation
// - Unlock needs first key then second key
// - Relock automatically after next operation completes
// - Wrong key write disables flash until reset
// - Operation while not unlocked disables until reset
// - Read returns state code in bits 1:0
// - Register answers at 0xB7 on every page
`timescale 1ns/1ns
module fwk_guard
  import fwk_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  output logic            SFR_HIT,
  input  wire logic       FLASH_OP_START,
  input  wire logic       FLASH_OP_DONE,
  output logic            FLASH_OP_ALLOW
);

  typedef struct packed {
    fwk_state_e state;
    logic       busy;
    logic [7:0] rdata;
  } fwk_regs_s;

  fwk_regs_s  cur_q;
  fwk_regs_s  nxt_d;
  fwk_state_e key_next;
  logic       sel;

  // Page select is not an input at all, so every page sees the register
  assign sel = (SFR_ADDR == FWK_ADDR_LOCK_KEY);

  fwk_key_decode u_dec (
    .state      (cur_q.state),
    .wdata      (SFR_WDATA),
    .next_state (key_next)
  );

  function automatic logic [7:0] fwk_read_value(input fwk_state_e s);
    logic [7:0] v;
    v = 8'h00;
    case (s)
      FWK_LOCKED:   v[FWK_STATE_LSB +: FWK_STATE_W] = FWK_CODE_LOCKED;
      FWK_FIRST:    v[FWK_STATE_LSB +: FWK_STATE_W] = FWK_CODE_FIRST;
      FWK_UNLOCKED: v[FWK_STATE_LSB +: FWK_STATE_W] = FWK_CODE_UNLOCKED;
      default:      v[FWK_STATE_LSB +: FWK_STATE_W] = FWK_CODE_DISABLED;
    endcase
    return v;
  endfunction

  always_comb begin
    nxt_d = cur_q;
    if (sel && SFR_RD) begin
      nxt_d.rdata = fwk_read_value(cur_q.state);
    end
    case (cur_q.state)
      FWK_LOCKED, FWK_FIRST: begin
        if (FLASH_OP_START) begin
          nxt_d.state = FWK_DISABLED;
        end else if (sel && SFR_WR) begin
          nxt_d.state = key_next;
        end
      end
      FWK_UNLOCKED: begin
        if (FLASH_OP_START) begin
          nxt_d.busy = 1'b1;
        end
        if (cur_q.busy && FLASH_OP_DONE) begin
          nxt_d.state = FWK_LOCKED;
          nxt_d.busy  = 1'b0;
        end else if (cur_q.busy && FLASH_OP_START) begin
          nxt_d.state = FWK_DISABLED;
        end else if (sel && SFR_WR) begin
          nxt_d.state = key_next;
        end
      end
      FWK_DISABLED: begin
        // Only reset leaves this state
        nxt_d.busy = 1'b0;
      end
      default: nxt_d.state = FWK_DISABLED;
    endcase
    if (nxt_d.state != FWK_UNLOCKED) begin
      nxt_d.busy = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cur_q.state <= FWK_LOCKED;
      cur_q.busy  <= 1'b0;
      cur_q.rdata <= FWK_RESET_LOCK_KEY;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign SFR_RDATA      = cur_q.rdata;
  assign SFR_HIT        = sel;
  // Only the first operation start after unlock is allowed through
  assign FLASH_OP_ALLOW = (cur_q.state == FWK_UNLOCKED) && !cur_q.busy;

  a_key_unlock: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_FIRST && sel && SFR_WR && SFR_WDATA == FWK_KEY_SECOND && !FLASH_OP_START)
    |=> cur_q.state == FWK_UNLOCKED)
    else $error("second key did not unlock");

  a_relock_done: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_UNLOCKED && cur_q.busy && FLASH_OP_DONE) |=> cur_q.state == FWK_LOCKED)
    else $error("no relock after operation");

  a_bad_key: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_LOCKED && sel && SFR_WR && SFR_WDATA != FWK_KEY_FIRST) |=> cur_q.state == FWK_DISABLED)
    else $error("wrong key did not disable");

  a_locked_op: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state inside {FWK_LOCKED, FWK_FIRST} && FLASH_OP_START) |=> cur_q.state == FWK_DISABLED)
    else $error("operation while locked not disabled");

  a_disabled_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
    cur_q.state == FWK_DISABLED |=> cur_q.state == FWK_DISABLED && !FLASH_OP_ALLOW)
    else $error("disabled state left without reset");

  a_read_code: assert property (@(posedge CLK) disable iff (!RST_B)
    (SFR_RD && SFR_ADDR == FWK_ADDR_LOCK_KEY) |=> SFR_RDATA[1:0] == $past(cur_q.state) && SFR_RDATA[7:2] == 6'h00)
    else $error("read code mismatch");

  a_addr_decode: assert property (@(posedge CLK) disable iff (!RST_B)
    (SFR_WR && SFR_ADDR != FWK_ADDR_LOCK_KEY && !FLASH_OP_START && !FLASH_OP_DONE)
    |=> cur_q.state == $past(cur_q.state))
    else $error("foreign address changed state");

  a_reset_lock: assert property (@(posedge CLK)
    !RST_B |=> cur_q.state == FWK_LOCKED && !FLASH_OP_ALLOW)
    else $error("reset did not lock");

  a_first_key: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_LOCKED && sel && SFR_WR && SFR_WDATA == FWK_KEY_FIRST && !FLASH_OP_START)
    |=> cur_q.state == FWK_FIRST)
    else $error("first key not taken");

  a_first_wait: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_FIRST && !(sel && SFR_WR) && !FLASH_OP_START)
    |=> cur_q.state == FWK_FIRST)
    else $error("first key state lost");

  a_locked_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_LOCKED && !(sel && SFR_WR) && !FLASH_OP_START)
    |=> cur_q.state == FWK_LOCKED)
    else $error("locked state left without key");

  a_unlock_allow: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_FIRST && sel && SFR_WR && SFR_WDATA == FWK_KEY_SECOND && !FLASH_OP_START)
    |=> FLASH_OP_ALLOW)
    else $error("unlock did not allow operation");

  a_allow_rise: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(FLASH_OP_ALLOW)
    |-> $past(cur_q.state) == FWK_FIRST && $past(SFR_WDATA) == FWK_KEY_SECOND)
    else $error("allow rose without key pair");

  a_first_wrong: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_FIRST && sel && SFR_WR && SFR_WDATA != FWK_KEY_SECOND && !FLASH_OP_START)
    |=> cur_q.state == FWK_DISABLED)
    else $error("wrong second key did not disable");

  a_unlock_write: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_UNLOCKED && sel && SFR_WR && !(cur_q.busy && FLASH_OP_DONE))
    |=> cur_q.state == FWK_DISABLED)
    else $error("key write while unlocked kept access");

  a_first_start: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_UNLOCKED && !cur_q.busy && FLASH_OP_START && !(sel && SFR_WR))
    |=> cur_q.state == FWK_UNLOCKED && !FLASH_OP_ALLOW)
    else $error("first operation not consumed");

  a_busy_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_UNLOCKED && cur_q.busy && !FLASH_OP_DONE && !FLASH_OP_START && !(sel && SFR_WR))
    |=> cur_q.state == FWK_UNLOCKED && !FLASH_OP_ALLOW)
    else $error("running operation state lost");

  a_relock_allow: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_UNLOCKED && cur_q.busy && FLASH_OP_DONE)
    |=> !FLASH_OP_ALLOW)
    else $error("allow kept after operation");

  a_done_idle: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_LOCKED && FLASH_OP_DONE && !FLASH_OP_START && !(sel && SFR_WR))
    |=> cur_q.state == FWK_LOCKED)
    else $error("stray done changed state");

  a_second_start: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_UNLOCKED && cur_q.busy && FLASH_OP_START && !FLASH_OP_DONE)
    |=> cur_q.state == FWK_DISABLED)
    else $error("second operation not refused");

  // Read data stands until the next read, so slow polling sees a steady code
  a_read_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    !(sel && SFR_RD)
    |=> $stable(SFR_RDATA))
    else $error("read data changed without read");

  a_read_disabled: assert property (@(posedge CLK) disable iff (!RST_B)
    (cur_q.state == FWK_DISABLED && sel && SFR_RD)
    |=> SFR_RDATA == {6'h00, FWK_CODE_DISABLED})
    else $error("disabled code not read");

  a_read_reset: assert property (@(posedge CLK)
    !RST_B
    |=> SFR_RDATA == FWK_RESET_LOCK_KEY)
    else $error("read data not cleared by reset");

endmodule

// >>> design/fwk_key_decode.sv
// Classifies a lock register write against the key sequence.
// Assumes write data and state are from the same clock domain.
`timescale 1ns/1ns
module fwk_key_decode
  import fwk_pkg::*;
(
  input  wire fwk_state_e state,
  input  wire logic [7:0] wdata,
  output fwk_state_e      next_state
);
  always_comb begin
    case (state)
      FWK_LOCKED:   next_state = (wdata == FWK_KEY_FIRST) ? FWK_FIRST : FWK_DISABLED;
      FWK_FIRST:    next_state = (wdata == FWK_KEY_SECOND) ? FWK_UNLOCKED : FWK_DISABLED;
      // A further key write while unlocked breaks the sequence too
      FWK_UNLOCKED: next_state = FWK_DISABLED;
      default:      next_state = FWK_DISABLED;
    endcase
  end
endmodule

// >>> design/fwk_pkg.sv
// Package for the flash write lock and key guard.
// Assumes an 8-bit special function register bus on the core clock.
package fwk_pkg;
  localparam logic [7:0] FWK_ADDR_LOCK_KEY  = 8'hB7;
  localparam logic [7:0] FWK_KEY_FIRST      = 8'hA5;
  localparam logic [7:0] FWK_KEY_SECOND     = 8'hF1;
  localparam int         FWK_STATE_LSB      = 0;
  localparam int         FWK_STATE_W        = 2;
  localparam logic [1:0] FWK_CODE_LOCKED    = 2'h0;
  localparam logic [1:0] FWK_CODE_FIRST     = 2'h1;
  localparam logic [1:0] FWK_CODE_UNLOCKED  = 2'h2;
  localparam logic [1:0] FWK_CODE_DISABLED  = 2'h3;
  localparam logic [7:0] FWK_RESET_LOCK_KEY = 8'h00;

  typedef enum logic [1:0] {
    FWK_LOCKED,
    FWK_FIRST,
    FWK_UNLOCKED,
    FWK_DISABLED
  } fwk_state_e;
endpackage

// >>> verification/flash_write_lock_key_tb.sv
// Testbench for the flash write lock and key guard.
// Assumes the guard ports of fwk_guard and a 100 ns core clock.
`timescale 1ns/1ns
module flash_write_lock_key_tb;
  import fwk_pkg::*;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       hit;
  logic       op_st = 1'b0;
  logic       op_dn = 1'b0;
  logic       allow;
  int         n_errors = 0;
  int         cmp_count = 0;
  fwk_guard dut (.CLK(clk), .RST_B(rst_b), .SFR_ADDR(addr), .SFR_WR(wr_s), .SFR_RD(rd_s),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SFR_HIT(hit), .FLASH_OP_START(op_st),
    .FLASH_OP_DONE(op_dn), .FLASH_OP_ALLOW(allow));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] exp);
    @(posedge clk);
    addr <= FWK_ADDR_LOCK_KEY;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic op(input logic s, input logic d);
    @(posedge clk);
    op_st <= s;
    op_dn <= d;
    @(posedge clk);
    op_st <= 1'b0;
    op_dn <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    n_errors++;
    end_of_test();
  end
  initial begin
    do_reset();
    rd_chk({6'h00, FWK_CODE_LOCKED});
    wr(8'hB6, FWK_KEY_FIRST);
    chk({7'h00, hit}, 8'h00);
    rd_chk({6'h00, FWK_CODE_LOCKED});
    chk({7'h00, hit}, 8'h01);
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_FIRST);
    rd_chk({6'h00, FWK_CODE_FIRST});
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_SECOND);
    chk({7'h00, allow}, 8'h01);
    rd_chk({6'h00, FWK_CODE_UNLOCKED});
    op(1'b1, 1'b0);
    chk({7'h00, allow}, 8'h00);
    op(1'b0, 1'b1);
    rd_chk({6'h00, FWK_CODE_LOCKED});
    // Wrong second key, then a correct pair must stay refused
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_FIRST);
    wr(FWK_ADDR_LOCK_KEY, 8'h00);
    rd_chk({6'h00, FWK_CODE_DISABLED});
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_FIRST);
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_SECOND);
    rd_chk({6'h00, FWK_CODE_DISABLED});
    chk({7'h00, allow}, 8'h00);
    do_reset();
    rd_chk({6'h00, FWK_CODE_LOCKED});
    op(1'b1, 1'b0);
    rd_chk({6'h00, FWK_CODE_DISABLED});
    // Reset clears the disable; a second start in one operation is refused
    do_reset();
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_FIRST);
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_SECOND);
    chk({7'h00, allow}, 8'h01);
    op(1'b1, 1'b0);
    op(1'b1, 1'b0);
    rd_chk({6'h00, FWK_CODE_DISABLED});
    chk({7'h00, allow}, 8'h00);
    // Any key write while unlocked breaks the sequence, except in the cycle an operation completes
    do_reset();
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_FIRST);
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_SECOND);
    wr(FWK_ADDR_LOCK_KEY, FWK_KEY_FIRST);
    rd_chk({6'h00, FWK_CODE_DISABLED});
    chk({7'h00, allow}, 8'h00);
    do_reset();
    wr(FWK_ADDR_LOCK_KEY, 8'h3C);
    rd_chk({6'h00, FWK_CODE_DISABLED});
    end_of_test();
  end
endmodule
